// [src/tacm_map.vh]
// Register map, field positions, reset values and timing counts for the tilt alarm framer
`ifndef TACM_MAP_VH
`define TACM_MAP_VH
// APB byte offsets
`define TACM_CTRL_OFS      12'h000
`define TACM_THRESH_OFS    12'h004
`define TACM_PERIOD_OFS    12'h008
`define TACM_STATUS_OFS    12'h00C
`define TACM_REQ_OFS       12'h010
`define TACM_NV_OFS        12'h014
// Control fields
`define TACM_CTRL_MSG_EN   0
`define TACM_CTRL_SSI_EN   1
`define TACM_CTRL_RST      32'h0000_0003
// Defaults
`define TACM_THRESH_RST    16'h001E
`define TACM_PERIOD_MS_RST 16'h0064
// Alarm codes
`define TACM_ST_OFF        2'h0
`define TACM_ST_ON         2'h1
`define TACM_ST_ERR        2'h2
`define TACM_ST_NA         2'h3
// Frame identity
`define TACM_PGN           18'h0FF00
`define TACM_PRIO          3'h6
`define TACM_DLC           4'h1
// Timebase: one millisecond at 50 MHz
`define TACM_CLK_HZ        50000000
`define TACM_MS_CYCLES     (`TACM_CLK_HZ / 1000)
`endif

// [src/tacm_framer.v]
// Tilt alarm comparator and periodic one-byte proprietary frame generator with APB registers
//
// Functional notes
// R1 - The alarm is on when the gravity angle is at or above the threshold, default 30.
// R2 - The alarm is a two-bit code: 00 off, 01 tilted, 10 error, 11 not available.
// R3 - Frames use proprietary group 65280, priority 6, one data byte, every 100 ms when enabled.
// R4 - A period of zero sends frames only when a request arrives.
// R5 - The alarm code sits in data byte 1 starting at bit 1, two bits wide.
// R6 - Clearing the slope sensor message enable stops that message completely.
// R7 - Every changed setting is pushed to non-volatile storage at once, with no save command.
// R8 - Each frame carries the alarm sampled in its own period; unused data bits are ones.
`timescale 1ns/1ps
`include "tacm_map.vh"
module tacm_framer #(
    parameter MS_CYCLES = `TACM_MS_CYCLES
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Angle source
    input  wire [15:0] angle,
    input  wire        angle_valid,
    input  wire        angle_fault,
    // Frame to CAN controller
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg  [28:0] tx_id,
    output reg  [3:0]  tx_dlc,
    output reg  [7:0]  tx_data,
    // Remote request for the frame
    input  wire        rx_request,
    // Default slope sensor message gate
    output wire        ssi_tx_en,
    // Non-volatile store write port
    output reg         nv_wr,
    output reg  [11:0] nv_addr,
    output reg  [31:0] nv_data,
    input  wire        nv_busy
);
    // Settings, counters and the registered alarm
    reg  [31:0] ctrl_ff;
    reg  [15:0] thresh_ff;
    reg  [15:0] period_ff;
    reg  [31:0] ms_cnt_ff;
    reg  [15:0] per_cnt_ff;
    reg         req_pend_ff;
    reg  [1:0]  alarm_ff;
    // Next-state values
    reg  [31:0] nxt_prdata;
    reg  [1:0]  nxt_alarm;
    // Handshake and timing strobes
    wire        wr_acc;
    wire        ms_tick;
    wire        per_hit;
    wire        send;

    // Decode of a register offset into its one-hot slot
    // Shared by the write, read, error and store paths
    function [5:0] reg_hit;
        input [11:0] a;
        begin
            reg_hit = {a == `TACM_NV_OFS, a == `TACM_REQ_OFS, a == `TACM_STATUS_OFS,
                       a == `TACM_PERIOD_OFS, a == `TACM_THRESH_OFS, a == `TACM_CTRL_OFS};
        end
    endfunction

    // Zero-wait slave; unmapped offsets flag an error
    // Read data is staged in the setup cycle, so the access phase never waits
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(|reg_hit(paddr));
    assign wr_acc  = psel & penable & pwrite;

    // Register writes
    // Read-only and unmapped offsets fall through and leave every setting as it was
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= `TACM_CTRL_RST;
            thresh_ff <= `TACM_THRESH_RST;
            period_ff <= `TACM_PERIOD_MS_RST;
        end else if (wr_acc) begin
            if (reg_hit(paddr) == 6'h01) begin
                // Only the two enable bits exist; the rest read back as zero
                ctrl_ff <= pwdata & 32'h0000_0003;
            end
            if (reg_hit(paddr) == 6'h02) begin
                thresh_ff <= pwdata[15:0]; // R1
            end
            if (reg_hit(paddr) == 6'h04) begin
                period_ff <= pwdata[15:0];
            end
        end
    end

    // Mirror each setting write to the store, so no save command is needed
    // Only the three settings are stored; status and request writes are not
    // Limitation: nv_busy is not consulted, the store must absorb one word per write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_wr   <= 1'b0;
            nv_addr <= 12'h000;
            nv_data <= 32'h0000_0000;
        end else begin
            nv_wr <= wr_acc & (|(reg_hit(paddr) & 6'h07)); // R7
            if (wr_acc) begin
                nv_addr <= paddr;
                nv_data <= pwdata;
            end
        end
    end

    // Read mux
    // Decoded from the setup-cycle address and captured one edge later
    // Unmapped offsets read as zero
    always @* begin
        nxt_prdata = 32'h0000_0000;
        case (reg_hit(paddr))
            6'h01: nxt_prdata = ctrl_ff;
            6'h02: nxt_prdata = {16'h0000, thresh_ff};
            6'h04: nxt_prdata = {16'h0000, period_ff};
            6'h08: nxt_prdata = {29'h0, req_pend_ff, alarm_ff};
            6'h20: nxt_prdata = {31'h0, nv_busy};
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Staged at setup so the word stands for the whole access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= nxt_prdata;
        end
    end

    // Alarm code; fault outranks not-available, which outranks compare
    // Unsigned compare; a zero threshold keeps the alarm on while the angle is valid
    always @* begin
        if (angle_fault) begin
            nxt_alarm = `TACM_ST_ERR; // R2
        end else if (!angle_valid) begin
            nxt_alarm = `TACM_ST_NA; // R2
        end else if (angle >= thresh_ff) begin
            nxt_alarm = `TACM_ST_ON; // R1
        end else begin
            nxt_alarm = `TACM_ST_OFF;
        end
    end

    // Registered so frames and status reads see the same code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_ff <= `TACM_ST_NA;
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    // Millisecond timebase and period counter
    // A zero period parks the counter so a later nonzero period starts a full interval
    // The >= compare lets a period shortened below the count fire at the next tick
    assign ms_tick = (ms_cnt_ff == MS_CYCLES - 1);
    assign per_hit = ms_tick & (period_ff != 16'h0000) & (per_cnt_ff >= period_ff - 16'h0001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_ff  <= 32'h0000_0000;
            per_cnt_ff <= 16'h0000;
        end else begin
            ms_cnt_ff <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
            if (per_hit | (period_ff == 16'h0000)) begin
                per_cnt_ff <= 16'h0000;
            end else if (ms_tick) begin
                per_cnt_ff <= per_cnt_ff + 16'h0001; // R3
            end
        end
    end

    // Pending request; a new request beats the clear on send
    // Dropping the message enable also discards a request not yet served
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_pend_ff <= 1'b0;
        end else if (rx_request | (wr_acc & reg_hit(paddr) == 6'h10)) begin
            req_pend_ff <= 1'b1; // R4
        end else if (send | ~ctrl_ff[`TACM_CTRL_MSG_EN]) begin
            req_pend_ff <= 1'b0;
        end
    end

    // Period zero leaves only the request path open
    // A tick that lands while a frame still waits is dropped rather than queued
    assign send = ctrl_ff[`TACM_CTRL_MSG_EN] & ~tx_valid & (per_hit | req_pend_ff); // R4

    // Frame out; held until the controller takes it, a late frame drops a tick
    // Id is priority, group and a fixed global source address
    // Bits 7..2 pad with ones; the alarm code takes bits 1..0
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_id    <= 29'h0000_0000;
            tx_dlc   <= 4'h0;
            tx_data  <= 8'hFF;
        end else if (send) begin
            tx_valid <= 1'b1;
            tx_id    <= {`TACM_PRIO, `TACM_PGN, 8'hFF}; // R3
            tx_dlc   <= `TACM_DLC; // R3
            tx_data  <= {6'h3F, alarm_ff}; // R5 R8
        end else if (tx_valid & tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // Default slope message gate
    // The slope message itself lives outside; only its gate is held here
    assign ssi_tx_en = ctrl_ff[`TACM_CTRL_SSI_EN]; // R6
endmodule

// [testbench/tacm_framer_sva.sv]
// Port-level property checker for the tilt alarm framer
`timescale 1ns/1ps
module tacm_framer_chk #(
    parameter MS_CYCLES = 50000
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Frame side
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [28:0] tx_id,
    input wire logic [3:0]  tx_dlc,
    input wire logic [7:0]  tx_data,
    // Slope gate and store
    input wire logic        ssi_tx_en,
    input wire logic        nv_wr,
    input wire logic [11:0] nv_addr,
    input wire logic [31:0] nv_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed APB access
    wire acc = psel && penable;
    property p_id; tx_valid |-> tx_id == {3'h6, 18'h0FF00, 8'hFF} && tx_dlc == 4'h1; endproperty
    a_id: assert property (p_id) else $error("frame id or length wrong");
    property p_pad; tx_valid |-> tx_data[7:2] == 6'h3F; endproperty
    a_pad: assert property (p_pad) else $error("unused data bits not ones");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("frame changed while waiting");
    property p_rel; tx_valid && tx_ready |=> !tx_valid; endproperty
    a_rel: assert property (p_rel) else $error("frame not released");
    property p_nv; acc && pwrite && paddr <= 12'h008 && paddr[1:0] == 2'h0
        |=> nv_wr && nv_addr == $past(paddr) && nv_data == $past(pwdata); endproperty
    a_nv: assert property (p_nv) else $error("setting not stored");
    property p_nv_none; acc && pwrite && paddr >= 12'h00C |=> !nv_wr; endproperty
    a_nv_none: assert property (p_nv_none) else $error("spurious store");
    property p_ssi; acc && pwrite && paddr == 12'h000
        |=> ssi_tx_en == $past(pwdata[1]); endproperty
    a_ssi: assert property (p_ssi) else $error("slope gate wrong");
    property p_err; acc |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("slave error wrong");
    c_frame: cover property (tx_valid && tx_ready);
    c_stall: cover property (tx_valid && !tx_ready);
    c_nv: cover property (nv_wr);
endmodule

// [testbench/tacm_can_model.sv]
// Far-side frame acceptor standing in for the CAN controller
`timescale 1ns/1ps
module tacm_can_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bus load control
    input  wire logic       slow,
    // Frame in
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Observations
    output int              n_frames,
    output logic [7:0]      last_data
);
    logic [1:0] div_ff;
    // Slow mode takes one cycle in four, like a busy bus
    assign tx_ready = !slow || div_ff == 2'h3;
    // Count accepted frames, keep the last byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 2'h0;
            n_frames <= 0;
            last_data <= 8'h00;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (tx_valid && tx_ready) begin
                n_frames <= n_frames + 1;
                last_data <= tx_data;
            end
        end
    end
endmodule

// [testbench/tacm_framer_test.sv]
// Self-checking bench for the tilt alarm framer
`timescale 1ns/1ps
module tacm_framer_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err;
    logic        angle_valid = 0, angle_fault = 0, rx_request = 0, nv_busy = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [15:0] angle = 0;
    logic [17:0] cs [4] = '{18'h1001D, 18'h1001E, 18'h3001E, 18'h0001E};
    wire         pready, pslverr, tx_valid, tx_ready, ssi_tx_en, nv_wr;
    wire  [31:0] prdata, nv_data;
    wire  [28:0] tx_id;
    wire  [11:0] nv_addr;
    wire  [7:0]  tx_data, last_data;
    wire  [3:0]  tx_dlc;
    int          n_errors = 0, tests_run = 0, cyc = 0, nf, t0, n_frames;
    tacm_framer #(.MS_CYCLES(10)) u_dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .prdata      (prdata),
        .angle       (angle),
        .angle_valid (angle_valid),
        .angle_fault (angle_fault),
        .tx_valid    (tx_valid),
        .tx_ready    (tx_ready),
        .tx_id       (tx_id),
        .tx_dlc      (tx_dlc),
        .tx_data     (tx_data),
        .rx_request  (rx_request),
        .ssi_tx_en   (ssi_tx_en),
        .nv_wr       (nv_wr),
        .nv_addr     (nv_addr),
        .nv_data     (nv_data),
        .nv_busy     (nv_busy)
    );
    tacm_can_model u_far (
        .pclk      (pclk),
        .presetn   (presetn),
        .slow      (slow),
        .tx_valid  (tx_valid),
        .tx_data   (tx_data),
        .tx_ready  (tx_ready),
        .n_frames  (n_frames),
        .last_data (last_data)
    );
    always #10 pclk = ~pclk;
    // Cycle count doubles as the hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wfr;
        nf = n_frames;
        while (n_frames == nf) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 32'h3);
        apb(0, 12'h004, 0);
        chk("thresh", rd, 32'h1E);
        apb(0, 12'h008, 0);
        chk("period", rd, 32'h64);
        apb(0, 12'h018, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        // Store busy flag is visible to software
        nv_busy <= 1;
        apb(0, 12'h014, 0);
        chk("store busy", rd, 32'h1);
        nv_busy <= 0;
        $display("reset test done");
        // Threshold edge and every status code
        foreach (cs[i]) begin
            {angle_fault, angle_valid, angle} <= cs[i];
            repeat (3) @(posedge pclk);
            apb(0, 12'h00C, 0);
            chk("alarm", rd[1:0], i);
        end
        {angle_fault, angle_valid, angle} <= 18'h1001E;
        wfr;
        wfr;
        t0 = cyc;
        wfr;
        chk("interval", cyc - t0, 1000);
        chk("byte", last_data, 8'hFD);
        $display("periodic test done");
        apb(1, 12'h008, 0);
        apb(1, 12'h00C, 0);
        repeat (50) @(posedge pclk);
        nf = n_frames;
        repeat (300) @(posedge pclk);
        chk("quiet", n_frames - nf, 0);
        slow <= 1;
        rx_request <= 1;
        @(posedge pclk);
        rx_request <= 0;
        repeat (40) @(posedge pclk);
        chk("on request", n_frames - nf, 1);
        apb(0, 12'h00C, 0);
        chk("pending served", rd, 32'h1);
        apb(1, 12'h000, 0);
        chk("slope gate", ssi_tx_en, 0);
        apb(1, 12'h010, 1);
        repeat (40) @(posedge pclk);
        chk("disabled", n_frames - nf, 1);
        apb(0, 12'h00C, 0);
        chk("pending dropped", rd, 32'h1);
        $display("request test done");
        tally_and_finish;
    end
endmodule
bind tacm_framer tacm_framer_chk #(
    .MS_CYCLES (MS_CYCLES)
) u_chk (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pslverr   (pslverr),
    .tx_valid  (tx_valid),
    .tx_ready  (tx_ready),
    .tx_id     (tx_id),
    .tx_dlc    (tx_dlc),
    .tx_data   (tx_data),
    .ssi_tx_en (ssi_tx_en),
    .nv_wr     (nv_wr),
    .nv_addr   (nv_addr),
    .nv_data   (nv_data)
);
